// >>> core/ads_pkg.sv
// Shared constants and types of the audio decoder register bank.
// Assumes an 8-bit special-function register port on the core clock.
package ads_pkg;
   // Register addresses in the special-function space
   localparam logic [7:0] ADR_VOL_L = 8'h9E;
   localparam logic [7:0] ADR_VOL_R = 8'h9F;
   localparam logic [7:0] ADR_CON = 8'hAA;
   localparam logic [7:0] ADR_DAT = 8'hAC;
   localparam logic [7:0] ADR_ANC = 8'hAD;
   localparam logic [7:0] ADR_STA1 = 8'hAF;
   localparam logic [7:0] ADR_BAS = 8'hB4;
   localparam logic [7:0] ADR_MED = 8'hB5;
   localparam logic [7:0] ADR_STA = 8'hC8;
   // decoder_status field positions
   localparam int STA_ANC = 7;
   localparam int STA_REQ = 6;
   localparam int STA_LAY = 5;
   localparam int STA_SYN = 4;
   localparam int STA_CRC = 3;
   localparam int STA_FS = 1;
   localparam int STA_VER = 0;
   // request_status_aux and decoder_control field positions
   localparam int STA1_FREQ = 4;
   localparam int STA1_BREQ = 3;
   localparam int STA1_B0 = 0;
   localparam int CON_EN = 7;
   localparam int CON_BB = 6;
   localparam int CON_CRC = 5;
   // Reset values
   localparam logic [7:0] RST_STA = 8'h01;
   localparam logic [7:0] RST_STA1 = 8'h11;
   localparam logic [7:0] RST_CON = 8'h3F;
   localparam logic [7:0] RST_ANC = 8'h00;
   localparam logic [4:0] RST_GAIN = 5'h00;
   // Sizes
   localparam int GAIN_W = 5;
   localparam int NFLAG = 4;
   localparam int ANC_DEPTH = 8;
   localparam int ANC_AW = 3;
   // Index of each read-cleared flag in the flag bank
   localparam int EV_CRC = 0;
   localparam int EV_SYN = 1;
   localparam int EV_LAY = 2;
   localparam int EV_REQ = 3;

   typedef enum logic [2:0] {
      ADS_FS_22K05, ADS_FS_24K, ADS_FS_16K,
      ADS_FS_44K1, ADS_FS_48K, ADS_FS_32K, ADS_FS_RSVD
   } ads_rate_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ads_sfr_t;

   typedef struct packed {
      logic [1:0] fs;
      logic ver;
   } ads_frame_t;

   typedef struct packed {
      logic [GAIN_W-1:0] vol_l;
      logic [GAIN_W-1:0] vol_r;
      logic [GAIN_W-1:0] bass;
      logic [GAIN_W-1:0] mid;
   } ads_gain_t;

   function automatic ads_rate_t ads_fs_decode(input logic ver, input logic [1:0] fs);
      ads_rate_t r;
      r = ADS_FS_RSVD;
      unique case ({ver, fs})
         3'h0: r = ADS_FS_22K05;
         3'h1: r = ADS_FS_24K;
         3'h2: r = ADS_FS_16K;
         3'h4: r = ADS_FS_44K1;
         3'h5: r = ADS_FS_48K;
         3'h6: r = ADS_FS_32K;
         default: r = ADS_FS_RSVD;
      endcase
      return r;
   endfunction
endpackage

// >>> core/ads_flag_bank.sv
// Bank of sticky event flags, cleared together by one strobe.
// Assumes set inputs are single-cycle events on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ads_flag_bank
   import ads_pkg::*;
#(
   parameter int N = NFLAG
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [N-1:0] set,
   input wire logic clr,
   output logic [N-1:0] q
);
   logic [N-1:0] flag_ff;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         // An event in the clearing cycle survives
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) flag_ff[i] <= 1'b0;
            else if (set[i]) flag_ff[i] <= 1'b1;
            else if (clr) flag_ff[i] <= 1'b0;
         end
      end
   endgenerate
   assign q = flag_ff;
endmodule
`default_nettype wire

// >>> core/ads_anc_buf.sv
// Ancillary byte queue between frame parser and processor reads.
// Assumes at most one push and one pop per cycle; pushes when full are dropped.
`timescale 1ns/1ps
`default_nettype none
module ads_anc_buf
   import ads_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic push,
   input wire logic [7:0] din,
   input wire logic pop,
   output logic [7:0] head,
   output logic empty,
   output logic full
);
   logic [7:0] mem [ANC_DEPTH];
   logic [ANC_AW-1:0] wp_ff;
   logic [ANC_AW-1:0] rp_ff;
   logic [ANC_AW:0] cnt_ff;
   logic do_push;
   logic do_pop;

   assign empty = cnt_ff == '0;
   assign full = cnt_ff == (ANC_AW+1)'(ANC_DEPTH);
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign head = mem[rp_ff];

   // Storage has no reset; empty state hides its contents
   always_ff @(posedge clk) begin
      if (do_push) mem[wp_ff] <= din;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff <= wp_ff + ANC_AW'(do_push);
         rp_ff <= rp_ff + ANC_AW'(do_pop);
         cnt_ff <= cnt_ff + (ANC_AW+1)'(do_push) - (ANC_AW+1)'(do_pop);
      end
   end
endmodule
`default_nettype wire

// >>> core/ads_regs.sv
// Register bank of the hardwired audio frame decoder, seen by the 8-bit core.
// Assumes the core drives one register access per cycle on the special-function
// port and that decoder event inputs are single-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module ads_regs
   import ads_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire ads_sfr_t sfr,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic dec_frame_req,
   input wire logic dec_byte_req,
   input wire logic ev_layer_err,
   input wire logic ev_sync_err,
   input wire logic ev_crc_err,
   input wire logic frame_load,
   input wire ads_frame_t frame_info,
   input wire logic anc_push,
   input wire logic [7:0] anc_data,
   output logic [7:0] stream_byte,
   output logic stream_valid,
   output ads_gain_t gain,
   output logic dec_enable,
   output logic bass_boost,
   output logic crc_play,
   output ads_rate_t sample_rate,
   output logic dec_irq
);
   // Address decode
   wire logic hit_sta = sfr.addr == ADR_STA;
   wire logic hit_sta1 = sfr.addr == ADR_STA1;
   wire logic hit_dat = sfr.addr == ADR_DAT;
   wire logic hit_anc = sfr.addr == ADR_ANC;
   wire logic hit_con = sfr.addr == ADR_CON;
   wire logic hit_vl = sfr.addr == ADR_VOL_L;
   wire logic hit_vr = sfr.addr == ADR_VOL_R;
   wire logic hit_bas = sfr.addr == ADR_BAS;
   wire logic hit_med = sfr.addr == ADR_MED;
   wire logic hit_any = hit_sta | hit_sta1 | hit_dat | hit_anc | hit_con
                        | hit_vl | hit_vr | hit_bas | hit_med;

   wire logic rd_sta = sfr.rd && hit_sta;
   wire logic rd_anc = sfr.rd && hit_anc;
   wire logic wr_dat = sfr.wr && hit_dat;
   wire logic wr_con = sfr.wr && hit_con;
   wire logic wr_vl = sfr.wr && hit_vl;
   wire logic wr_vr = sfr.wr && hit_vr;
   wire logic wr_bas = sfr.wr && hit_bas;
   wire logic wr_med = sfr.wr && hit_med;

   assign sfr_hit = hit_any && (sfr.rd || sfr.wr);

   // Control and gain state
   logic [7:0] con_ff;
   logic [GAIN_W-1:0] vol_l_ff;
   logic [GAIN_W-1:0] vol_r_ff;
   logic [GAIN_W-1:0] bas_ff;
   logic [GAIN_W-1:0] med_ff;
   logic [1:0] fs_ff;
   logic ver_ff;
   ads_rate_t rate_ff;
   logic freq_ff;
   logic breq_ff;
   logic sta1_b0_ff;
   logic frame_req_d_ff;
   logic [7:0] stream_ff;
   logic stream_vld_ff;
   logic [7:0] rdata_ff;

   // Event flags
   logic [NFLAG-1:0] ev_set;
   logic [NFLAG-1:0] ev_q;
   wire logic req_rise = dec_frame_req && !frame_req_d_ff;

   assign ev_set[EV_REQ] = req_rise;
   assign ev_set[EV_LAY] = ev_layer_err;
   assign ev_set[EV_SYN] = ev_sync_err;
   assign ev_set[EV_CRC] = ev_crc_err;

   ads_flag_bank #(
      .N(NFLAG)
   ) u_flags (
      .clk(clk),
      .rst_b(rst_b),
      .set(ev_set),
      .clr(rd_sta),
      .q(ev_q)
   );

   // Ancillary queue
   logic [7:0] anc_head;
   logic anc_empty;
   logic anc_full;

   ads_anc_buf u_anc (
      .clk(clk),
      .rst_b(rst_b),
      .push(anc_push),
      .din(anc_data),
      .pop(rd_anc),
      .head(anc_head),
      .empty(anc_empty),
      .full(anc_full)
   );

   // Register images as read back
   wire logic anc_avail = !anc_empty;
   wire logic [7:0] sta_val = {anc_avail, ev_q[EV_REQ], ev_q[EV_LAY],
                               ev_q[EV_SYN], ev_q[EV_CRC], fs_ff, ver_ff};
   wire logic [7:0] sta1_val = {3'h0, freq_ff, breq_ff, 2'h0, sta1_b0_ff};
   // Empty queue reads as zero so a stray read shows no stale byte
   wire logic [7:0] anc_val = anc_empty ? RST_ANC : anc_head;

   function automatic logic [7:0] gain_byte(input logic [GAIN_W-1:0] g);
      return {3'h0, g};
   endfunction

   wire logic [7:0] rd_mux =
      hit_sta ? sta_val :
      hit_sta1 ? sta1_val :
      hit_anc ? anc_val :
      hit_con ? con_ff :
      hit_vl ? gain_byte(vol_l_ff) :
      hit_vr ? gain_byte(vol_r_ff) :
      hit_bas ? gain_byte(bas_ff) :
      hit_med ? gain_byte(med_ff) :
      8'h00;

   // Masks in control bits 4..0 line up with status flags 7..3
   wire logic [4:0] flag_vec = sta_val[7:3];
   assign dec_irq = |(flag_vec & ~con_ff[4:0]);

   // Read data is captured on the read strobe and held until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rdata_ff <= 8'h00;
      else if (sfr.rd) rdata_ff <= rd_mux;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) con_ff <= RST_CON;
      else if (wr_con) con_ff <= sfr.wdata;
   end

   // Only the five value bits are stored; upper bits cannot be set
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vol_l_ff <= RST_GAIN;
         vol_r_ff <= RST_GAIN;
         bas_ff <= RST_GAIN;
         med_ff <= RST_GAIN;
      end else begin
         if (wr_vl) vol_l_ff <= sfr.wdata[GAIN_W-1:0];
         if (wr_vr) vol_r_ff <= sfr.wdata[GAIN_W-1:0];
         if (wr_bas) bas_ff <= sfr.wdata[GAIN_W-1:0];
         if (wr_med) med_ff <= sfr.wdata[GAIN_W-1:0];
      end
   end

   // Frame header information
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fs_ff <= RST_STA[STA_FS+1:STA_FS];
         ver_ff <= RST_STA[STA_VER];
         rate_ff <= ads_fs_decode(RST_STA[STA_VER], RST_STA[STA_FS+1:STA_FS]);
      end else if (frame_load) begin
         fs_ff <= frame_info.fs;
         ver_ff <= frame_info.ver;
         rate_ff <= ads_fs_decode(frame_info.ver, frame_info.fs);
      end
   end

   // Request status; byte request set wins over the clearing write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         freq_ff <= RST_STA1[STA1_FREQ];
         breq_ff <= RST_STA1[STA1_BREQ];
         sta1_b0_ff <= RST_STA1[STA1_B0];
         frame_req_d_ff <= 1'b0;
      end else begin
         freq_ff <= dec_frame_req;
         frame_req_d_ff <= dec_frame_req;
         if (dec_byte_req) breq_ff <= 1'b1;
         else if (wr_dat) breq_ff <= 1'b0;
      end
   end

   // Stream byte goes to the decoder as a one-cycle strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stream_ff <= 8'h00;
         stream_vld_ff <= 1'b0;
      end else begin
         stream_vld_ff <= wr_dat;
         if (wr_dat) stream_ff <= sfr.wdata;
      end
   end

   assign sfr_rdata = rdata_ff;
   assign stream_byte = stream_ff;
   assign stream_valid = stream_vld_ff;
   assign gain = '{vol_l: vol_l_ff, vol_r: vol_r_ff, bass: bas_ff, mid: med_ff};
   assign dec_enable = con_ff[CON_EN];
   assign bass_boost = con_ff[CON_BB];
   assign crc_play = con_ff[CON_CRC];
   assign sample_rate = rate_ff;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_sta_read_quiet;
      rd_sta && !ev_layer_err && !ev_sync_err && !ev_crc_err && !req_rise;
   endsequence

   sequence s_layer_during_read;
      rd_sta && ev_layer_err;
   endsequence

   sequence s_sync_during_read;
      rd_sta && ev_sync_err;
   endsequence

   sequence s_crc_during_read;
      rd_sta && ev_crc_err;
   endsequence

   sequence s_byte_req_on_write;
      wr_dat && dec_byte_req;
   endsequence

   a_read_clears_flags: assert property (
      s_sta_read_quiet |=> (ev_q == '0) && (sta_val[STA_ANC] == !anc_empty))
      else $error("status read left an event flag set");

   a_set_beats_clear: assert property (
      s_layer_during_read |=> sta_val[STA_LAY] ##1 (sta_val[STA_LAY] || $past(rd_sta)))
      else $error("layer event lost in clearing cycle");

   a_sync_sets: assert property (
      ev_sync_err |=> sta_val[STA_SYN])
      else $error("sync error flag not set");

   a_crc_sets: assert property (
      ev_crc_err |=> sta_val[STA_CRC])
      else $error("checksum flag not set");

   a_req_rise_sets: assert property (
      (dec_frame_req && !frame_req_d_ff) |=> sta_val[STA_REQ])
      else $error("stream request flag not set on request");

   a_anc_flag_tracks: assert property (
      $fell(sta_val[STA_ANC]) |-> $past(rd_anc))
      else $error("ancillary flag cleared without a read");

   a_anc_push_shows: assert property (
      (anc_push && anc_empty && !rd_anc) |=> sta_val[STA_ANC])
      else $error("ancillary flag not set after push");

   a_status_readback: assert property (
      rd_sta |=> sfr_rdata == $past(sta_val))
      else $error("status read data wrong");

   a_breq_clears: assert property (
      (wr_dat && !dec_byte_req) |=> !sta1_val[STA1_BREQ] && stream_valid)
      else $error("byte request not cleared by stream write");

   a_freq_follows: assert property (
      dec_frame_req [*2] |-> sta1_val[STA1_FREQ])
      else $error("frame request flag dropped while requesting");

   a_ver_loads: assert property (
      frame_load |=> (sta_val[STA_VER] == $past(frame_info.ver))
                     && (sta_val[2:1] == $past(frame_info.fs)))
      else $error("frame information not loaded");

   a_rate_decode: assert property (
      frame_load && frame_info.fs == 2'h3 |=> sample_rate == ADS_FS_RSVD)
      else $error("reserved code not flagged");

   a_irq_masked: assert property (
      (con_ff[4:0] == 5'h1F) |-> !dec_irq)
      else $error("masked flag raised interrupt");

   a_gain_upper_zero: assert property (
      (sfr.rd && (hit_vl || hit_vr || hit_bas || hit_med || hit_sta1))
      |=> sfr_rdata[7:5] == 3'h0)
      else $error("reserved bits read nonzero");

   a_vol_write: assert property (
      wr_vl |=> gain.vol_l == $past(sfr.wdata[4:0]))
      else $error("left volume not written");

   a_anc_empty_zero: assert property (
      (rd_anc && anc_empty) |=> sfr_rdata == 8'h00)
      else $error("empty ancillary read not zero");

   a_sync_beats_clear: assert property (
      s_sync_during_read |=> sta_val[STA_SYN])
      else $error("sync event lost in clearing cycle");

   a_crc_beats_clear: assert property (
      s_crc_during_read |=> sta_val[STA_CRC])
      else $error("checksum event lost in clearing cycle");

   a_breq_set_wins: assert property (
      s_byte_req_on_write |=> sta1_val[STA1_BREQ])
      else $error("byte request lost on stream write");

   a_anc_pop_next: assert property (
      (rd_anc && !anc_empty) |=> sfr_rdata == $past(anc_head))
      else $error("ancillary read returned wrong byte");

   a_con_write: assert property (
      wr_con |=> {dec_enable, bass_boost, crc_play} == $past(sfr.wdata[7:5]))
      else $error("control bits not written");
endmodule
`default_nettype wire

// >>> dv/ads_cpu_model.sv
// Processor-side model issuing one special-function access at a time.
// Assumes the register bank samples rd and wr on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module ads_cpu_model
   import ads_pkg::*;
(
   input wire logic clk,
   output var ads_sfr_t sfr
);
   initial begin
      sfr = '0;
   end

   // Between accesses the bus shows inverted values, so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a inside {ADR_VOL_L, ADR_VOL_R, ADR_BAS, ADR_MED}) begin
         v[7:5] = 3'h0;
      end
      @(posedge clk);
      sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge clk);
      sfr <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      sfr <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
   endtask
endmodule
`default_nettype wire

// >>> dv/ads_regs_test.sv
// Self-checking bench of the audio decoder register bank.
// Assumes ads_pkg, ads_regs and ads_cpu_model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module ads_regs_test
   import ads_pkg::*;
;
   logic clk, rst_b, sfr_hit, dec_frame_req, dec_byte_req, frame_load, anc_push;
   ads_sfr_t sfr;
   logic [7:0] sfr_rdata, anc_data, stream_byte, v, sbase;
   logic [2:0] ev;
   ads_frame_t frame_info;
   logic stream_valid, dec_enable, bass_boost, crc_play, dec_irq, rd_seen;
   ads_gain_t gain;
   ads_rate_t sample_rate;
   int fails, checks;
   logic [7:0] rq[$];
   logic [7:0] sq[$];
   logic [7:0] ga[4] = '{ADR_VOL_L, ADR_VOL_R, ADR_BAS, ADR_MED};
   logic [7:0] gv[4];
   logic [7:0] ab[3];

   ads_regs u_ads_regs (.clk(clk), .rst_b(rst_b), .sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .dec_frame_req(dec_frame_req), .dec_byte_req(dec_byte_req), .ev_layer_err(ev[2]),
      .ev_sync_err(ev[1]), .ev_crc_err(ev[0]), .frame_load(frame_load), .frame_info(frame_info),
      .anc_push(anc_push), .anc_data(anc_data), .stream_byte(stream_byte), .stream_valid(stream_valid),
      .gain(gain), .dec_enable(dec_enable), .bass_boost(bass_boost), .crc_play(crc_play),
      .sample_rate(sample_rate), .dec_irq(dec_irq));

   ads_cpu_model u_ads_cpu_model (.clk(clk), .sfr(sfr));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] in_map(input logic [7:0] a);
      return {7'h0, a inside {ADR_VOL_L, ADR_VOL_R, ADR_CON, ADR_DAT, ADR_ANC, ADR_STA1, ADR_BAS, ADR_MED, ADR_STA}};
   endfunction

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      u_ads_cpu_model.rd(a);
   endtask

   task automatic complete_run();
      if (fails == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   function automatic ads_rate_t exp_rate(input int k);
      case (k)
         0: return ADS_FS_22K05;
         1: return ADS_FS_24K;
         2: return ADS_FS_16K;
         4: return ADS_FS_44K1;
         5: return ADS_FS_48K;
         6: return ADS_FS_32K;
         default: return ADS_FS_RSVD;
      endcase
   endfunction

   // Read data lands on the edge that takes rd, so it is compared one edge later
   always @(posedge clk) begin
      if (rd_seen === 1'b1) begin
         if (rq.size() > 0) check(sfr_rdata, rq.pop_front());
         else fails++;
      end
      if (stream_valid === 1'b1) begin
         if (sq.size() > 0) check(stream_byte, sq.pop_front());
         else fails++;
      end
      if (sfr.rd || sfr.wr) check({7'h0, sfr_hit}, in_map(sfr.addr));
      rd_seen <= sfr.rd;
   end

   initial begin
      #800000;
      fails++;
      complete_run();
   end

   initial begin
      rst_b = 1'b0;
      rd_seen = 1'b0;
      dec_frame_req = 1'b0;
      dec_byte_req = 1'b0;
      ev = 3'h0;
      frame_load = 1'b0;
      frame_info = '0;
      anc_push = 1'b0;
      anc_data = 8'h00;
      sbase = RST_STA;
      v = 8'($urandom(3388));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(ADR_STA, RST_STA);
      rd(ADR_ANC, RST_ANC);
      for (int i = 0; i < 4; i++) rd(ga[i], 8'h00);
      rd(8'h80, 8'h00);
      rd(ADR_DAT, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         gv[i] = {3'h0, v[4:0]};
         u_ads_cpu_model.wr(ga[i], v);
         rd(ga[i], gv[i]);
      end
      check({3'h0, gain.vol_l}, gv[0]);
      check({3'h0, gain.vol_r}, gv[1]);
      check({3'h0, gain.bass}, gv[2]);
      check({3'h0, gain.mid}, gv[3]);
      @(posedge clk) dec_frame_req <= 1'b1;
      repeat (2) @(posedge clk);
      rd(ADR_STA1, RST_STA1);
      rd(ADR_STA, 8'h41);
      rd(ADR_STA, 8'h01);
      @(posedge clk) dec_byte_req <= 1'b1;
      @(posedge clk) dec_byte_req <= 1'b0;
      rd(ADR_STA1, 8'h19);
      v = 8'($urandom);
      sq.push_back(v);
      u_ads_cpu_model.wr(ADR_DAT, v);
      rd(ADR_STA1, 8'h11);
      @(posedge clk) dec_frame_req <= 1'b0;
      repeat (2) @(posedge clk);
      rd(ADR_STA1, 8'h01);
      v = 8'($urandom);
      fork
         begin
            sq.push_back(v);
            u_ads_cpu_model.wr(ADR_DAT, v);
         end
         begin
            @(posedge clk) dec_byte_req <= 1'b1;
            @(posedge clk) dec_byte_req <= 1'b0;
         end
      join
      rd(ADR_STA1, 8'h09);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) ev <= 3'h1 << i;
         @(posedge clk) ev <= 3'h0;
         rd(ADR_STA, sbase | (8'h08 << i));
         rd(ADR_STA, sbase);
      end
      // Events in the very cycle of a status read must survive the clear
      fork
         rd(ADR_STA, sbase);
         begin
            @(posedge clk) ev <= 3'h7;
            @(posedge clk) ev <= 3'h0;
         end
      join
      rd(ADR_STA, sbase | 8'h38);
      // Unmask only the checksum flag so the interrupt has one cause
      u_ads_cpu_model.wr(ADR_CON, 8'hDE);
      @(posedge clk) ev <= 3'h1;
      @(posedge clk) ev <= 3'h0;
      @(posedge clk);
      #1 check({7'h0, dec_irq}, 8'h01);
      check({5'h0, dec_enable, bass_boost, crc_play}, 8'h06);
      rd(ADR_STA, 8'h09);
      #1 check({7'h0, dec_irq}, 8'h00);
      rd(ADR_CON, 8'hDE);
      u_ads_cpu_model.wr(ADR_CON, RST_CON);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         frame_info.fs <= 2'(k);
         frame_info.ver <= k[2];
         frame_load <= 1'b1;
         @(posedge clk) frame_load <= 1'b0;
         sbase = {5'h0, 2'(k), k[2]};
         rd(ADR_STA, sbase);
         check({5'h0, sample_rate}, {5'h0, exp_rate(k)});
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         ab[i] = 8'($urandom);
         anc_push <= 1'b1;
         anc_data <= ab[i];
      end
      @(posedge clk) anc_push <= 1'b0;
      rd(ADR_STA, sbase | 8'h80);
      rd(ADR_STA, sbase | 8'h80);
      for (int i = 0; i < 3; i++) rd(ADR_ANC, ab[i]);
      rd(ADR_STA, sbase);
      rd(ADR_ANC, 8'h00);
      u_ads_cpu_model.wr(ADR_STA, 8'hFF);
      rd(ADR_STA, sbase);
      @(posedge clk) rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(ADR_STA, RST_STA);
      rd(ADR_VOL_R, 8'h00);
      repeat (3) @(posedge clk);
      if (rq.size() != 0 || sq.size() != 0) fails++;
      complete_run();
   end
endmodule
`default_nettype wire
